// file: fcs_pkg.sv
package fcs_pkg;
	// Register indices on the plain register port.
	localparam logic [3:0] REG_CLKDIV = 4'h0;
	localparam logic [3:0] REG_PIDX = 4'h1;
	localparam logic [3:0] REG_PARAM = 4'h2;
	localparam logic [3:0] REG_STAT = 4'h3;
	localparam logic [3:0] REG_PPROT = 4'h4;
	localparam logic [3:0] REG_DPROT = 4'h5;
	localparam logic [3:0] REG_FAULT = 4'h6;
	localparam logic [3:0] REG_MARGIN = 4'h7;
	// Field positions.
	localparam int CLKDIV_LOADED_BIT = 7;
	localparam int STAT_COMMAND_COMPLETE_FLAG_BIT = 7;
	localparam int STAT_ACC_BIT = 5;
	localparam int STAT_VIOL_BIT = 4;
	localparam int PPROT_OPEN_BIT = 7;
	localparam int PPROT_UPPER_BIT = 5;
	localparam int PPROT_LOWER_BIT = 2;
	localparam int DPROT_OPEN_BIT = 7;
	localparam int FAULT_SINGLE_BIT = 1;
	localparam int FAULT_DOUBLE_BIT = 0;
	localparam int MARGIN_UNSEC_BIT = 15;
	// Reset values and the data-flash block select code.
	localparam logic [6:0] CLKDIV_RST = 7'h00;
	localparam logic [15:0] MARGIN_NORMAL = 16'h0000;
	localparam logic [1:0] DF_BLOCK_SEL = 2'h0;
	// Parameter buffer.
	localparam int PARAM_WORDS = 6;
	localparam logic [2:0] IDX_FIRST = 3'h0;
	localparam logic [2:0] IDX_KEYS = 3'h4;
	localparam logic [2:0] IDX_DPROG_MIN = 3'h2;
	localparam logic [2:0] IDX_DPROG_MAX = 3'h5;
	// Command codes.
	localparam logic [7:0] CMD_VERIFY_ALL = 8'h01;
	localparam logic [7:0] CMD_VERIFY_BLK = 8'h02;
	localparam logic [7:0] CMD_VERIFY_PSEC = 8'h03;
	localparam logic [7:0] CMD_READ_ONCE = 8'h04;
	localparam logic [7:0] CMD_PROG_P = 8'h06;
	localparam logic [7:0] CMD_PROG_ONCE = 8'h07;
	localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
	localparam logic [7:0] CMD_ERASE_BLK = 8'h09;
	localparam logic [7:0] CMD_ERASE_PSEC = 8'h0A;
	localparam logic [7:0] CMD_UNSECURE = 8'h0B;
	localparam logic [7:0] CMD_BACKDOOR = 8'h0C;
	localparam logic [7:0] CMD_USER_MARGIN = 8'h0D;
	localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0E;
	localparam logic [7:0] CMD_VERIFY_DSEC = 8'h10;
	localparam logic [7:0] CMD_PROG_D = 8'h11;
	localparam logic [7:0] CMD_ERASE_DSEC = 8'h12;

	typedef enum {ST_IDLE, ST_LOCAL, ST_ISSUE, ST_WAIT, ST_ISSUE2, ST_WAIT2} fcs_state_t;
	typedef enum logic [2:0] {CL_IDLE, CL_READ, CL_MARGIN, CL_PROG, CL_SECT, CL_MASS,
		CL_OTHER} fcs_cls_t;
endpackage : fcs_pkg

// file: fcs_sequencer.sv
`timescale 1ns/1ns
// How it works
// RL1: Block erase of program flash needs three bits.
// RL2: Code 0x0A erases one program sector.
// RL3: Code 0x0B erases all, then verifies all.
// RL4: Code 0x0C compares supplied keys with stored.
// RL5: Code 0x0D sets user margin per array.
// RL6: Code 0x0E sets field margin, special only.
// RL7: Codes 0x01/0x02 verify all or one block.
// RL8: Code 0x08 needs all four protect bits.
// RL9: Data block erase needs data protect-open.
// RL10: Code 0x10 verifies data words erased.
// RL11: Code 0x11 programs one to four words.
// RL12: Code 0x12 erases one data sector.
// RL13: Only listed array pairs may run together.
// RL14: Erase all and block erase are mass.
// RL15: Read after non-normal margin is margin read.
// RL16: Program/erase before divider set is access error.
// RL17: Unknown command code is access error.
// RL18: Reading busy block returns invalid data.
// RL19: Invalid read sets both faults if clear.
// RL20: Software clears error flags before launching.
// RL21: Software programs only erased words, once.
// RL22: Verify-all needs index zero, sets completion.
// RL23: Writing one to completion flag launches.
// RL24: Parameter index selects buffer word written.
// RL25: Rejected launch starts nothing, flag stays.
module fcs_sequencer
	import fcs_pkg::*;
#(
	parameter int DW = 16
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [3:0] reg_addr,
	input wire logic [DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DW-1:0] reg_rdata,
	input wire logic special_mode,
	input wire logic [63:0] stored_key,
	input wire logic array_done,
	input wire logic pf_rd,
	input wire logic df_rd,
	output logic rd_invalid,
	output logic op_start,
	output logic [7:0] op_cmd,
	output logic op_pf,
	output logic op_df,
	output logic [17:0] op_addr,
	output logic [DW-1:0] op_count,
	output logic [DW-1:0] pf_margin,
	output logic [DW-1:0] df_margin,
	output logic unsecured
);
	logic [6:0] clkdiv_r;
	logic [2:0] pidx_r;
	logic [DW-1:0] param_r [0:PARAM_WORDS-1];
	logic clkdiv_loaded_r, command_complete_flag_r, acc_r, viol_r, unsec_r;
	logic pp_open_r, pp_upper_r, pp_lower_r, dp_open_r;
	logic fault_s_r, fault_d_r, run_pf_r, run_df_r, rd_invalid_r, op_start_r;
	logic [DW-1:0] pf_margin_r, df_margin_r, rdata_r, op_count_r;
	fcs_state_t state_r;
	logic [7:0] cmd_r, op_cmd_r;
	logic [17:0] op_addr_r;

	logic [7:0] code;
	logic launch, valid_code, needs_div, is_local, sel_df, acc_fail, viol_fail, accept;
	logic tgt_pf, tgt_df, w_stat, pf_bad, df_bad, bad_read;
	fcs_cls_t run_cls;

	function automatic fcs_cls_t cls_of(input logic [7:0] c);
		case (c)
			CMD_ERASE_ALL, CMD_ERASE_BLK: cls_of = CL_MASS; // [RL14]
			CMD_ERASE_PSEC, CMD_ERASE_DSEC: cls_of = CL_SECT;
			CMD_PROG_P, CMD_PROG_ONCE, CMD_PROG_D: cls_of = CL_PROG;
			default: cls_of = CL_OTHER;
		endcase
	endfunction : cls_of
	function automatic logic pair_ok(input fcs_cls_t p, input fcs_cls_t d);
		pair_ok = (p == CL_READ && (d == CL_MARGIN || d == CL_PROG || d == CL_SECT)) ||
			(p == CL_MARGIN && d == CL_MARGIN) || (p == CL_SECT && d == CL_SECT) ||
			(p == CL_MASS && d == CL_MASS); // [RL13]
	endfunction : pair_ok
	assign code = param_r[0][15:8];
	assign sel_df = (param_r[0][1:0] == DF_BLOCK_SEL);
	assign w_stat = reg_wr && reg_addr == REG_STAT;
	assign launch = w_stat && reg_wdata[STAT_COMMAND_COMPLETE_FLAG_BIT] && command_complete_flag_r; // [RL23]

	always_comb begin
		valid_code = 1'b1;
		needs_div = 1'b0;
		is_local = 1'b0;
		tgt_pf = 1'b0;
		tgt_df = 1'b0;
		case (code)
			CMD_VERIFY_ALL, CMD_ERASE_ALL: begin // [RL7] [RL8]
				tgt_pf = 1'b1;
				tgt_df = 1'b1;
				needs_div = (code == CMD_ERASE_ALL);
			end
			CMD_UNSECURE: begin // [RL3]
				tgt_pf = 1'b1;
				tgt_df = 1'b1;
				needs_div = 1'b1;
			end
			CMD_VERIFY_BLK: begin // [RL7]
				tgt_pf = !sel_df;
				tgt_df = sel_df;
			end
			CMD_ERASE_BLK: begin // [RL1] [RL9]
				tgt_pf = !sel_df;
				tgt_df = sel_df;
				needs_div = 1'b1;
			end
			CMD_VERIFY_PSEC, CMD_READ_ONCE: tgt_pf = 1'b1;
			CMD_PROG_P, CMD_PROG_ONCE, CMD_ERASE_PSEC: begin // [RL2]
				tgt_pf = 1'b1;
				needs_div = 1'b1;
			end
			CMD_VERIFY_DSEC: tgt_df = 1'b1; // [RL10]
			CMD_PROG_D, CMD_ERASE_DSEC: begin // [RL11] [RL12]
				tgt_df = 1'b1;
				needs_div = 1'b1;
			end
			CMD_BACKDOOR, CMD_USER_MARGIN, CMD_FIELD_MARGIN: is_local = 1'b1;
			default: valid_code = 1'b0; // [RL17]
		endcase
	end

	always_comb begin
		acc_fail = 1'b0;
		viol_fail = 1'b0;
		if (!valid_code) begin
			acc_fail = 1'b1; // [RL17]
		end else if (needs_div && !clkdiv_loaded_r) begin
			acc_fail = 1'b1; // [RL16]
		end else if (code == CMD_FIELD_MARGIN && !special_mode) begin
			acc_fail = 1'b1; // [RL6]
		end else if ((code == CMD_VERIFY_ALL || code == CMD_VERIFY_BLK) && pidx_r != IDX_FIRST) begin
			acc_fail = 1'b1; // [RL22]
		end else if (code == CMD_PROG_D && (pidx_r < IDX_DPROG_MIN || pidx_r > IDX_DPROG_MAX)) begin
			acc_fail = 1'b1; // [RL11]
		end else if (code == CMD_BACKDOOR && pidx_r != IDX_KEYS) begin
			acc_fail = 1'b1; // [RL4]
		end else if (code == CMD_ERASE_ALL) begin
			viol_fail = !(pp_lower_r && pp_upper_r && pp_open_r && dp_open_r); // [RL8]
		end else if (code == CMD_ERASE_BLK && !sel_df) begin
			viol_fail = !(pp_lower_r && pp_upper_r && pp_open_r); // [RL1]
		end else if (code == CMD_ERASE_BLK && sel_df) begin
			viol_fail = !dp_open_r; // [RL9]
		end
	end

	// A rejected launch never leaves idle, so no array operation can start.
	assign accept = launch && !acc_fail && !viol_fail; // [RL25]
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			clkdiv_r <= CLKDIV_RST;
			clkdiv_loaded_r <= 1'b0;
		end else if (reg_wr && reg_addr == REG_CLKDIV && command_complete_flag_r) begin
			clkdiv_r <= reg_wdata[6:0];
			clkdiv_loaded_r <= 1'b1; // [RL16]
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pidx_r <= IDX_FIRST;
		end else if (reg_wr && reg_addr == REG_PIDX && command_complete_flag_r) begin
			pidx_r <= reg_wdata[2:0]; // [RL24]
		end
	end
	// Buffer words are frozen while a command runs so the array sees stable operands.
	genvar gi;
	generate
		for (gi = 0; gi < PARAM_WORDS; gi++) begin : g_param
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					param_r[gi] <= '0;
				end else if (reg_wr && reg_addr == REG_PARAM && command_complete_flag_r && pidx_r == gi) begin
					param_r[gi] <= reg_wdata; // [RL24]
				end
			end
		end
	endgenerate

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pp_open_r <= 1'b0;
			pp_upper_r <= 1'b0;
			pp_lower_r <= 1'b0;
			dp_open_r <= 1'b0;
		end else if (reg_wr && command_complete_flag_r) begin
			if (reg_addr == REG_PPROT) begin
				pp_open_r <= reg_wdata[PPROT_OPEN_BIT];
				pp_upper_r <= reg_wdata[PPROT_UPPER_BIT];
				pp_lower_r <= reg_wdata[PPROT_LOWER_BIT];
			end
			if (reg_addr == REG_DPROT) begin
				dp_open_r <= reg_wdata[DPROT_OPEN_BIT];
			end
		end
	end
	// Error flags: a new rejection wins over a clear in the same write.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			acc_r <= 1'b0;
			viol_r <= 1'b0;
		end else begin
			if (launch && acc_fail) begin
				acc_r <= 1'b1; // [RL16] [RL17]
			end else if (state_r == ST_LOCAL && cmd_r == CMD_BACKDOOR &&
				{param_r[1], param_r[2], param_r[3], param_r[4]} != stored_key) begin
				acc_r <= 1'b1; // [RL4]
			end else if (w_stat && reg_wdata[STAT_ACC_BIT]) begin
				acc_r <= 1'b0; // [RL20]
			end
			if (launch && viol_fail) begin
				viol_r <= 1'b1; // [RL1] [RL8] [RL9]
			end else if (w_stat && reg_wdata[STAT_VIOL_BIT]) begin
				viol_r <= 1'b0; // [RL20]
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_r <= ST_IDLE;
			command_complete_flag_r <= 1'b1;
			cmd_r <= 8'h00;
			run_pf_r <= 1'b0;
			run_df_r <= 1'b0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (accept) begin
						command_complete_flag_r <= 1'b0; // [RL23]
						cmd_r <= code;
						run_pf_r <= tgt_pf && !is_local;
						run_df_r <= tgt_df && !is_local;
						state_r <= is_local ? ST_LOCAL : ST_ISSUE;
					end
				end
				ST_LOCAL: begin
					command_complete_flag_r <= 1'b1;
					state_r <= ST_IDLE;
				end
				ST_ISSUE: state_r <= ST_WAIT;
				ST_WAIT: begin
					if (array_done) begin
						if (cmd_r == CMD_UNSECURE) begin
							state_r <= ST_ISSUE2; // [RL3]
						end else begin
							command_complete_flag_r <= 1'b1; // [RL22] [RL23]
							run_pf_r <= 1'b0;
							run_df_r <= 1'b0;
							state_r <= ST_IDLE;
						end
					end
				end
				ST_ISSUE2: state_r <= ST_WAIT2;
				ST_WAIT2: begin
					if (array_done) begin
						command_complete_flag_r <= 1'b1;
						run_pf_r <= 1'b0;
						run_df_r <= 1'b0;
						state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// The unsecure command is split into an erase-all pass and a verify-all pass.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			op_start_r <= 1'b0;
			op_cmd_r <= 8'h00;
			op_addr_r <= '0;
			op_count_r <= '0;
		end else begin
			op_start_r <= (state_r == ST_ISSUE) || (state_r == ST_ISSUE2);
			if (state_r == ST_ISSUE) begin
				op_cmd_r <= (cmd_r == CMD_UNSECURE) ? CMD_ERASE_ALL : cmd_r; // [RL3]
				op_addr_r <= {param_r[0][1:0], param_r[1]};
				op_count_r <= (cmd_r == CMD_PROG_D) ?
					DW'(pidx_r - IDX_DPROG_MIN + 3'h1) : param_r[2]; // [RL11]
			end else if (state_r == ST_ISSUE2) begin
				op_cmd_r <= CMD_VERIFY_ALL; // [RL3]
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pf_margin_r <= MARGIN_NORMAL;
			df_margin_r <= MARGIN_NORMAL;
			unsec_r <= 1'b0;
		end else begin
			if (state_r == ST_LOCAL && (cmd_r == CMD_USER_MARGIN || cmd_r == CMD_FIELD_MARGIN)) begin
				if (sel_df) begin
					df_margin_r <= param_r[1]; // [RL5] [RL6]
				end else begin
					pf_margin_r <= param_r[1]; // [RL5] [RL6]
				end
			end
			if (state_r == ST_LOCAL && cmd_r == CMD_BACKDOOR &&
				{param_r[1], param_r[2], param_r[3], param_r[4]} == stored_key) begin
				unsec_r <= 1'b1; // [RL4]
			end
			if (state_r == ST_WAIT2 && array_done) begin
				unsec_r <= 1'b1; // [RL3]
			end
		end
	end

	// Reads collide when their own array is busy or the pair shares hardware.
	assign run_cls = cls_of(cmd_r);
	always_comb begin
		pf_bad = 1'b0;
		df_bad = 1'b0;
		if (pf_rd) begin
			pf_bad = !command_complete_flag_r && (run_pf_r || (run_df_r && !pair_ok((pf_margin_r != MARGIN_NORMAL) ?
				CL_MARGIN : CL_READ, run_cls))); // [RL18] [RL15] [RL13]
		end
		if (df_rd) begin
			df_bad = !command_complete_flag_r && (run_df_r || (run_pf_r && !pair_ok(run_cls,
				(df_margin_r != MARGIN_NORMAL) ? CL_MARGIN : CL_READ))); // [RL18] [RL15] [RL13]
		end
	end
	assign bad_read = pf_bad || df_bad;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rd_invalid_r <= 1'b0;
			fault_s_r <= 1'b0;
			fault_d_r <= 1'b0;
		end else begin
			rd_invalid_r <= bad_read; // [RL18]
			if (bad_read && !fault_s_r && !fault_d_r) begin
				fault_s_r <= 1'b1; // [RL19]
				fault_d_r <= 1'b1; // [RL19]
			end else if (reg_wr && reg_addr == REG_FAULT) begin
				if (reg_wdata[FAULT_SINGLE_BIT]) begin
					fault_s_r <= 1'b0;
				end
				if (reg_wdata[FAULT_DOUBLE_BIT]) begin
					fault_d_r <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= '0;
			if (reg_rd) begin
				case (reg_addr)
					REG_CLKDIV: rdata_r <= DW'({clkdiv_loaded_r, clkdiv_r});
					REG_PIDX: rdata_r <= DW'(pidx_r);
					REG_PARAM: rdata_r <= (pidx_r < PARAM_WORDS) ? param_r[pidx_r] : '0;
					REG_STAT: begin
						rdata_r[STAT_COMMAND_COMPLETE_FLAG_BIT] <= command_complete_flag_r;
						rdata_r[STAT_ACC_BIT] <= acc_r;
						rdata_r[STAT_VIOL_BIT] <= viol_r;
					end
					REG_PPROT: begin
						rdata_r[PPROT_OPEN_BIT] <= pp_open_r;
						rdata_r[PPROT_UPPER_BIT] <= pp_upper_r;
						rdata_r[PPROT_LOWER_BIT] <= pp_lower_r;
					end
					REG_DPROT: rdata_r[DPROT_OPEN_BIT] <= dp_open_r;
					REG_FAULT: begin
						rdata_r[FAULT_SINGLE_BIT] <= fault_s_r;
						rdata_r[FAULT_DOUBLE_BIT] <= fault_d_r;
					end
					REG_MARGIN: rdata_r[MARGIN_UNSEC_BIT] <= unsec_r;
					default: rdata_r <= '0;
				endcase
			end
		end
	end

	assign reg_rdata = rdata_r;
	assign rd_invalid = rd_invalid_r;
	assign op_start = op_start_r;
	assign op_cmd = op_cmd_r;
	assign op_pf = run_pf_r;
	assign op_df = run_df_r;
	assign op_addr = op_addr_r;
	assign op_count = op_count_r;
	assign pf_margin = pf_margin_r;
	assign df_margin = df_margin_r;
	assign unsecured = unsec_r;
endmodule : fcs_sequencer

// file: fcs_checker.sv
`timescale 1ns/1ns
module fcs_checker
	import fcs_pkg::*;
#(
	parameter int DW = 16
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic pf_rd,
	input wire logic df_rd,
	input wire logic array_done,
	input wire logic rd_invalid,
	input wire logic op_start,
	input wire logic [7:0] op_cmd,
	input wire logic op_pf,
	input wire logic op_df,
	input wire logic [DW-1:0] op_count,
	input wire logic [DW-1:0] pf_margin
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);
	start_busy_a: assert property (op_start |-> (op_pf || op_df))
		else $error("op_start without a busy array");
	start_pulse_a: assert property (op_start |=> !op_start)
		else $error("op_start longer than one cycle");
	cmd_held_a: assert property ($changed(op_cmd) |-> op_start)
		else $error("op_cmd changed without a start");
	cmd_valid_a: assert property (op_start |-> op_cmd inside {[8'h01:8'h04], [8'h06:8'h0A],
		[8'h10:8'h12]}) else $error("array given an invalid command");
	mass_both_a: assert property (op_start && op_cmd == CMD_ERASE_ALL |-> op_pf && op_df)
		else $error("erase all not on both arrays");
	count_range_a: assert property (op_start && op_cmd == CMD_PROG_D |->
		op_count inside {[1:4]}) else $error("data program count out of range");
	inv_cause_a: assert property (rd_invalid |-> $past(pf_rd || df_rd) && $past(op_pf || op_df))
		else $error("invalid read flagged without cause");
	own_busy_a: assert property ((pf_rd && op_pf || df_rd && op_df) && !array_done
		|=> rd_invalid) else $error("read of busy array not flagged");
	margin_read_a: assert property (pf_rd && pf_margin != 0 && op_df && !op_pf
		&& !array_done |=> rd_invalid) else $error("margin read beside data op not flagged");
	pair_ok_a: assert property (pf_rd && pf_margin == 0 && op_df && !op_pf &&
		(op_cmd == CMD_PROG_D || op_cmd == CMD_ERASE_DSEC) |=> !rd_invalid)
		else $error("allowed read flagged invalid");
endmodule : fcs_checker

bind fcs_sequencer fcs_checker #(.DW(DW)) u_fcs_checker (.clock, .resetn, .pf_rd, .df_rd,
	.array_done, .rd_invalid, .op_start, .op_cmd, .op_pf, .op_df, .op_count, .pf_margin);

// file: tb_fcs_sequencer.sv
`timescale 1ns/1ns
module tb_fcs_sequencer
	import fcs_pkg::*;
;
	logic clock;
	logic resetn;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [15:0] reg_rdata;
	logic special_mode;
	logic [63:0] stored_key;
	logic array_done;
	logic pf_rd;
	logic df_rd;
	logic rd_invalid;
	logic op_start;
	logic [7:0] op_cmd;
	logic op_pf;
	logic op_df;
	logic [17:0] op_addr;
	logic [15:0] op_count;
	logic [15:0] pf_margin;
	logic [15:0] df_margin;
	logic unsecured;
	int fails = 0;
	int n_tests = 0;
	int n_start = 0;
	int n_inv = 0;
	logic use_df = 1'b0;
	logic [15:0] cmds = 16'h0000;
	logic [7:0] bad [3] = '{8'h05, 8'h0F, 8'h13};
	logic [7:0] good [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h0A, 8'h10, 8'h12};

	fcs_sequencer u_fcs_sequencer (.clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .special_mode, .stored_key, .array_done, .pf_rd, .df_rd, .rd_invalid,
		.op_start, .op_cmd, .op_pf, .op_df, .op_addr, .op_count, .pf_margin, .df_margin,
		.unsecured);

	always #50 clock = ~clock;

	// Starts and invalid reads are counted here so that one-cycle pulses are never missed.
	always @(posedge clock) begin
		if (op_start === 1'b1) begin
			n_start <= n_start + 1;
			cmds <= {cmds[7:0], op_cmd};
		end
		if (rd_invalid === 1'b1)
			n_inv <= n_inv + 1;
	end

	task test_done();
		$display("checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done

	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h, expected %h", $time, g, e);
		end
	endtask : chk

	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	task rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		v = reg_rdata;
	endtask : rd

	task rc(input logic [3:0] a, input logic [15:0] e);
		logic [15:0] v;
		rd(a, v);
		chk(v, e);
	endtask : rc

	task pw(input logic [2:0] i, input logic [15:0] d);
		wr(REG_PIDX, {13'h0000, i});
		wr(REG_PARAM, d);
	endtask : pw

	task clr();
		wr(REG_STAT, 16'h0030);
	endtask : clr

	// Launch, optionally read program or data flash (per use_df) mid-run, answer st array runs, then poll.
	task run(input logic [15:0] se, input int st, input logic pr);
		int s0;
		logic [15:0] v;
		s0 = n_start;
		wr(REG_STAT, 16'h0080);
		rd(REG_STAT, v);
		if (st > 0)
			chk(v[7], 1'b0);
		if (pr) begin
			@(posedge clock);
			pf_rd <= !use_df;
			df_rd <= use_df;
			@(posedge clock);
			pf_rd <= 1'b0;
			df_rd <= 1'b0;
		end
		repeat (st) begin
			@(posedge clock);
			array_done <= 1'b1;
			@(posedge clock);
			array_done <= 1'b0;
			repeat (3) @(posedge clock);
		end
		for (int k = 0; k < 20 && v[7] !== 1'b1; k++)
			rd(REG_STAT, v);
		if (v[7] !== 1'b1) begin
			fails++;
			test_done();
		end
		chk(n_start - s0, st);
		chk(v, se);
	endtask : run

	initial begin
		clock = 1'b0;
		resetn = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		special_mode = 1'b0;
		stored_key = 64'h1111_2222_3333_4445;
		array_done = 1'b0;
		pf_rd = 1'b0;
		df_rd = 1'b0;
		repeat (12) @(posedge clock);
		resetn <= 1'b1;
		rc(REG_STAT, 16'h0080);
		rc(REG_FAULT, 16'h0000);
		rc(REG_MARGIN, 16'h0000);
		rc(4'h9, 16'h0000);
		$display("reset test done");
		pw(IDX_FIRST, 16'h0A01);
		run(16'h00A0, 0, 1'b0);
		clr();
		rc(REG_STAT, 16'h0080);
		foreach (bad[i]) begin
			pw(IDX_FIRST, {bad[i], 8'h01});
			run(16'h00A0, 0, 1'b0);
			clr();
		end
		wr(REG_CLKDIV, 16'h0005);
		rc(REG_CLKDIV, 16'h0085);
		pw(IDX_FIRST, 16'h0101);
		wr(REG_PIDX, 16'h0001);
		run(16'h00A0, 0, 1'b0);
		clr();
		$display("access error test done");
		// Only the program sector erase collides with the program read; the data one may not.
		foreach (good[i]) begin
			pw(IDX_FIRST, {good[i], 8'h01});
			run(16'h0080, 1, good[i] == 8'h0A || good[i] == 8'h12);
			chk(cmds[7:0], good[i]);
			chk(op_addr, 18'h10000);
		end
		chk(n_inv, 1);
		rc(REG_FAULT, 16'h0003);
		wr(REG_FAULT, 16'h0003);
		rc(REG_FAULT, 16'h0000);
		$display("command map test done");
		wr(REG_PPROT, 16'h0084);
		pw(IDX_FIRST, 16'h0901);
		run(16'h0090, 0, 1'b0);
		clr();
		wr(REG_PPROT, 16'h00A4);
		run(16'h0080, 1, 1'b0);
		pw(IDX_FIRST, 16'h0900);
		run(16'h0090, 0, 1'b0);
		clr();
		pw(IDX_FIRST, 16'h0800);
		run(16'h0090, 0, 1'b0);
		clr();
		wr(REG_DPROT, 16'h0080);
		run(16'h0080, 1, 1'b0);
		chk(cmds[7:0], CMD_ERASE_ALL);
		pw(IDX_FIRST, 16'h0900);
		run(16'h0080, 1, 1'b0);
		$display("protection test done");
		pw(IDX_FIRST, 16'h0D01);
		pw(3'h1, 16'h0002);
		run(16'h0080, 0, 1'b0);
		chk(pf_margin, 16'h0002);
		pw(IDX_FIRST, 16'h0E00);
		pw(3'h1, 16'h0003);
		run(16'h00A0, 0, 1'b0);
		clr();
		@(posedge clock);
		special_mode <= 1'b1;
		run(16'h0080, 0, 1'b0);
		chk(df_margin, 16'h0003);
		pw(IDX_FIRST, 16'h1100);
		pw(IDX_DPROG_MAX, 16'h1234);
		run(16'h0080, 1, 1'b1);
		chk(n_inv, 2);
		chk(op_count, 16'h0004);
		$display("margin test done");
		pw(IDX_FIRST, 16'h0C00);
		for (int i = 1; i < 5; i++)
			pw(3'(i), 16'(16'h1111 * i));
		run(16'h00A0, 0, 1'b0);
		chk(unsecured, 1'b0);
		clr();
		pw(IDX_FIRST, 16'h0B00);
		use_df = 1'b1;
		run(16'h0080, 2, 1'b1);
		chk(cmds, 16'h0801);
		chk(unsecured, 1'b1);
		chk(n_inv, 3);
		$display("security test done");
		@(posedge clock);
		resetn <= 1'b0;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		chk(unsecured, 1'b0);
		rc(REG_STAT, 16'h0080);
		stored_key <= 64'h1111_2222_3333_4444;
		pw(IDX_FIRST, 16'h0C00);
		for (int i = 1; i < 5; i++)
			pw(3'(i), 16'(16'h1111 * i));
		run(16'h0080, 0, 1'b0);
		chk(unsecured, 1'b1);
		$display("reset and key test done");
		test_done();
	end
endmodule : tb_fcs_sequencer
